// file: rtl/exception_lowpower_unit.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Function
// - reset sets both the nonmaskable and global mask bits
// - tap may clear the nonmaskable mask but never set it again; return from interrupt restores it to the stacked value
// - nonmaskable pin outranks all globally masked sources; those keep their order
// - maskable entry sets global mask after flags stacked; nonmaskable mask untouched
// - nonmaskable entry sets both mask bits after flags stacked
// - return from interrupt restores both mask bits to stacked values
// - every unimplemented opcode on all four pages raises an illegal trap
// - trap return address is the first byte of the offending opcode
// - software trap is taken regardless of masks and sets global mask
// - maskable request pin defaults to low level sensitive
// - enabled source with flag set requests service until flag clears
// - wait halts processing until an unmasked request; oscillator keeps running
// - during wait the bus repeatedly reads the stacked flags address
// - wait stops the timer only with global mask set and watchdog disabled
// - stop enters only with stop disable bit clear, else no operation
// - stop halts every clock, oscillator too, and holds all state
// - stop ends on low request pin, low reset, or pending edge request
// - maskable pin level wakes stop only with global mask clear; a latched edge wakes it regardless
// - nonmaskable pin always wakes stop; serviced only when unmasked
// - leaving stop applies stabilisation delay unless restart delay bit cleared
// - delay always follows power-on reset, never a warm reset
module exception_lowpower_unit #(
	parameter int                               NUM_SOURCES          = 15,
	parameter int                               RESTART_DELAY_CYCLES = exc_pkg::RESTART_DELAY_DEFAULT,
	parameter logic [exc_pkg::OPCODE_MAP_W-1:0] IMPLEMENTED_MAP      = '1
)(
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic                   cold_start,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// request pins
	input  wire logic                   irq_pin_n,
	input  wire logic                   nonmaskable_request_pin_n,
	// on-chip sources, index 0 ranks highest
	input  wire logic [NUM_SOURCES-1:0] source_flag,
	input  wire logic [NUM_SOURCES-1:0] source_enable,
	// core instruction events
	input  wire logic                   opcode_fetch,
	input  wire logic [1:0]             opcode_page,
	input  wire logic [7:0]             opcode_byte,
	input  wire logic [15:0]            opcode_addr,
	input  wire logic                   tap_exec,
	input  wire logic                   tap_x,
	input  wire logic                   tap_i,
	input  wire logic                   tap_s,
	input  wire logic                   rti_exec,
	input  wire logic                   rti_x,
	input  wire logic                   rti_i,
	input  wire logic                   rti_s,
	input  wire logic                   software_trap_instruction,
	input  wire logic                   wait_instruction,
	input  wire logic [15:0]            wait_flags_addr,
	input  wire logic                   stop_exec,
	input  wire logic                   flags_stacked,
	// condition code register
	output logic                        mask_x,
	output logic                        mask_i,
	output logic                        mask_s,
	// service request to the core
	output logic                        service_req,
	output logic [2:0]                  service_cause,
	output logic [3:0]                  service_source,
	output logic [15:0]                 trap_return_pc,
	// low power controls
	output logic                        cpu_halted,
	output logic                        wait_read_active,
	output logic [15:0]                 wait_read_addr,
	output logic                        timer_run,
	output logic                        osc_enable,
	output logic                        clocks_run
);

	localparam int DELAY_W = $clog2(RESTART_DELAY_CYCLES + 1);
	localparam logic [DELAY_W-1:0] DELAY_LOAD = DELAY_W'(RESTART_DELAY_CYCLES - 1);

	exc_pkg::power_state_t pwr_state;
	exc_pkg::power_state_t next_pwr_state;
	exc_pkg::cause_t       next_cause;
	logic [3:0]            next_source;
	logic [DELAY_W-1:0]    delay_count;
	logic                  restart_delay_bit;
	logic                  watchdog_disable_bit;
	logic                  irq_edge_mode;
	logic                  irq_pin_d;
	logic                  irq_edge_latch;
	logic                  irq_active;
	logic                  nmi_active;
	logic                  trap_pending;
	logic                  swi_pending;
	logic                  fetch_d;
	logic [15:0]           fetch_addr_d;
	logic [15:0]           flags_addr;
	logic                  stop_wake;
	logic                  running;
	logic                  apb_write;
	logic [NUM_SOURCES-1:0] source_req;
	logic                  after_reset;

	opcode_map_if map ();

	opcode_map_rom #(
		.IMPLEMENTED_MAP (IMPLEMENTED_MAP)
	) u_map (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.map     (map)
	);

	assign source_req = source_flag & source_enable;
	assign nmi_active = !nonmaskable_request_pin_n;
	// level mode lets several open-drain sources share the pin
	assign irq_active = irq_edge_mode ? irq_edge_latch : !irq_pin_n;
	assign running    = (pwr_state != exc_pkg::pwr_stop);
	assign apb_write  = psel && penable && pready && pwrite;

	// apb slave: one access cycle, unmapped offsets answer with an error
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable)
			begin
				if (paddr == exc_pkg::CTRL_OFFSET)
				begin
					prdata[exc_pkg::CTRL_DELAY_BIT] <= restart_delay_bit;
					prdata[exc_pkg::CTRL_WDOG_BIT]  <= watchdog_disable_bit;
					prdata[exc_pkg::CTRL_EDGE_BIT]  <= irq_edge_mode;
				end
				else if (paddr == exc_pkg::STATUS_OFFSET)
				begin
					prdata[exc_pkg::STAT_X_BIT]    <= mask_x;
					prdata[exc_pkg::STAT_I_BIT]    <= mask_i;
					prdata[exc_pkg::STAT_S_BIT]    <= mask_s;
					prdata[exc_pkg::STAT_TRAP_BIT] <= trap_pending;
					prdata[exc_pkg::STAT_SWI_BIT]  <= swi_pending;
					prdata[exc_pkg::STAT_EDGE_BIT] <= irq_edge_latch;
					prdata[exc_pkg::STAT_STATE_LSB +: exc_pkg::STAT_STATE_W] <= pwr_state;
					prdata[exc_pkg::STAT_CAUSE_LSB +: exc_pkg::STAT_CAUSE_W] <= service_cause;
				end
				else
					pslverr <= 1'b1;
			end
		end
	end

	// control register; reset re-arms the restart delay
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			restart_delay_bit    <= exc_pkg::CTRL_RESET[exc_pkg::CTRL_DELAY_BIT];
			watchdog_disable_bit <= exc_pkg::CTRL_RESET[exc_pkg::CTRL_WDOG_BIT];
			irq_edge_mode        <= exc_pkg::CTRL_RESET[exc_pkg::CTRL_EDGE_BIT];
		end
		else if (apb_write && paddr == exc_pkg::CTRL_OFFSET)
		begin
			restart_delay_bit    <= pwdata[exc_pkg::CTRL_DELAY_BIT];
			watchdog_disable_bit <= pwdata[exc_pkg::CTRL_WDOG_BIT];
			irq_edge_mode        <= pwdata[exc_pkg::CTRL_EDGE_BIT];
		end
	end

	// condition code mask bits; frozen while stopped
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mask_x <= 1'b1;
			mask_i <= 1'b1;
			mask_s <= 1'b1;
		end
		else if (!running)
		begin
			mask_x <= mask_x;
		end
		else if (flags_stacked)
		begin
			mask_i <= 1'b1;
			if (service_cause == exc_pkg::cause_nmi)
				mask_x <= 1'b1;
		end
		else if (rti_exec)
		begin
			mask_x <= rti_x;
			mask_i <= rti_i;
			mask_s <= rti_s;
		end
		else if (tap_exec)
		begin
			mask_x <= mask_x && tap_x;
			mask_i <= tap_i;
			mask_s <= tap_s;
		end
	end

	// edge capture for the maskable pin; a new edge beats the clear at entry
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_pin_d      <= 1'b1;
			irq_edge_latch <= 1'b0;
		end
		else
		begin
			irq_pin_d <= irq_pin_n;
			if (irq_edge_mode && irq_pin_d && !irq_pin_n)
				irq_edge_latch <= 1'b1;
			else if (flags_stacked && service_cause == exc_pkg::cause_irq_pin)
				irq_edge_latch <= 1'b0;
		end
	end

	// illegal opcode lookup, pipelined alongside the rom read
	assign map.rd_en = opcode_fetch;
	assign map.addr  = {opcode_page, opcode_byte};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_d      <= 1'b0;
			fetch_addr_d <= 16'h0000;
		end
		else
		begin
			fetch_d <= opcode_fetch;
			if (opcode_fetch)
				fetch_addr_d <= opcode_addr;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trap_pending   <= 1'b0;
			trap_return_pc <= 16'h0000;
		end
		else if (fetch_d && !map.implemented)
		begin
			trap_pending   <= 1'b1;
			trap_return_pc <= fetch_addr_d;
		end
		else if (flags_stacked && service_cause == exc_pkg::cause_illegal)
			trap_pending <= 1'b0;
	end

	// software trap request, held until its own entry
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			swi_pending <= 1'b0;
		else if (software_trap_instruction)
			swi_pending <= 1'b1;
		else if (flags_stacked && service_cause == exc_pkg::cause_swi)
			swi_pending <= 1'b0;
	end

	// priority: traps, then the nonmaskable pin, then maskable pin and sources
	always_comb
	begin
		next_cause  = exc_pkg::cause_none;
		next_source = 4'h0;
		if (trap_pending)
			next_cause = exc_pkg::cause_illegal;
		else if (swi_pending)
			next_cause = exc_pkg::cause_swi;
		else if (nmi_active && !mask_x)
			next_cause = exc_pkg::cause_nmi;
		else if (!mask_i && irq_active)
			next_cause = exc_pkg::cause_irq_pin;
		else if (!mask_i && |source_req)
		begin
			next_cause = exc_pkg::cause_source;
			for (int k = NUM_SOURCES - 1; k >= 0; k--)
			begin
				if (source_req[k])
					next_source = 4'(k);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			service_req    <= 1'b0;
			service_cause  <= exc_pkg::cause_none;
			service_source <= 4'h0;
		end
		else
		begin
			service_req    <= (next_cause != exc_pkg::cause_none);
			service_cause  <= next_cause;
			service_source <= next_source;
		end
	end

	// wake from stop; an edge request that is already latched also counts
	assign stop_wake = (!irq_pin_n && !mask_i) || nmi_active || irq_edge_latch;

	always_comb
	begin
		next_pwr_state = pwr_state;
		case (pwr_state)
			exc_pkg::pwr_boot:
				next_pwr_state = cold_start ? exc_pkg::pwr_restart : exc_pkg::pwr_run;
			exc_pkg::pwr_run:
				if (wait_instruction)
					next_pwr_state = exc_pkg::pwr_wait;
				else if (stop_exec && !mask_s)
					next_pwr_state = exc_pkg::pwr_stop;
			exc_pkg::pwr_wait:
				if (next_cause != exc_pkg::cause_none)
					next_pwr_state = exc_pkg::pwr_run;
			exc_pkg::pwr_stop:
				if (stop_wake)
					next_pwr_state = restart_delay_bit ? exc_pkg::pwr_restart : exc_pkg::pwr_run;
			exc_pkg::pwr_restart:
				if (delay_count == '0)
					next_pwr_state = exc_pkg::pwr_run;
			default:
				next_pwr_state = exc_pkg::pwr_run;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pwr_state <= exc_pkg::pwr_boot;
		else
			pwr_state <= next_pwr_state;
	end

	// stabilisation counter, loaded on entry to restart
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			delay_count <= DELAY_LOAD;
		else if (pwr_state != exc_pkg::pwr_restart)
			delay_count <= DELAY_LOAD;
		else if (delay_count != '0)
			delay_count <= delay_count - 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_addr <= 16'h0000;
		else if (pwr_state == exc_pkg::pwr_run && wait_instruction)
			flags_addr <= wait_flags_addr;
	end

	// low power outputs follow the state that is being entered
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_halted       <= 1'b1;
			wait_read_active <= 1'b0;
			wait_read_addr   <= 16'h0000;
			timer_run        <= 1'b0;
			osc_enable       <= 1'b1;
			clocks_run       <= 1'b0;
		end
		else
		begin
			cpu_halted       <= (next_pwr_state != exc_pkg::pwr_run);
			wait_read_active <= (next_pwr_state == exc_pkg::pwr_wait);
			wait_read_addr   <= (pwr_state == exc_pkg::pwr_run) ? wait_flags_addr : flags_addr;
			timer_run        <= (next_pwr_state == exc_pkg::pwr_run) ||
			                    (next_pwr_state == exc_pkg::pwr_wait && !(mask_i && watchdog_disable_bit));
			osc_enable       <= (next_pwr_state != exc_pkg::pwr_stop);
			clocks_run       <= (next_pwr_state == exc_pkg::pwr_run) || (next_pwr_state == exc_pkg::pwr_wait);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			after_reset <= 1'b1;
		else
			after_reset <= 1'b0;
	end

	reset_masks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		after_reset |-> (mask_x && mask_i))
		else $error("masks not set after reset");

	x_stays_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(mask_x) |-> $past(flags_stacked) || $past(rti_exec))
		else $error("nonmaskable mask set by software");

	nmi_ranks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(nmi_active && !mask_x && !trap_pending && !swi_pending) |=> (service_cause == exc_pkg::cause_nmi))
		else $error("nonmaskable request not ranked first");

	entry_sets_i_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flags_stacked && running && service_cause != exc_pkg::cause_nmi) |=> (mask_i && mask_x == $past(mask_x)))
		else $error("maskable entry mask update wrong");

	nmi_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flags_stacked && running && service_cause == exc_pkg::cause_nmi) |=> (mask_x && mask_i))
		else $error("nonmaskable entry masks not set");

	rti_restore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rti_exec && !flags_stacked && running) |=> (mask_x == $past(rti_x) && mask_i == $past(rti_i)))
		else $error("return did not restore masks");

	trap_pc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(opcode_fetch ##1 !map.implemented) |=> (trap_pending && trap_return_pc == $past(opcode_addr, 2)))
		else $error("illegal trap address wrong");

	level_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!irq_edge_mode && !irq_pin_n && !mask_i) |=> service_req)
		else $error("low level request not served");

	wait_reads_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_wait) |-> (wait_read_active && wait_read_addr == flags_addr))
		else $error("wait bus reads wrong address");

	wait_timer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_wait && mask_i && watchdog_disable_bit) |=>
		(pwr_state != exc_pkg::pwr_wait || !timer_run))
		else $error("timer runs in quiet wait");

	stop_nop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_run && stop_exec && mask_s) |=> (pwr_state != exc_pkg::pwr_stop))
		else $error("stop taken with stop disable set");

	stop_clocks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_stop) |-> (!osc_enable && !clocks_run && cpu_halted))
		else $error("clocks alive in stop");

	irq_masked_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_stop && mask_i && nonmaskable_request_pin_n && !irq_edge_latch) |=>
		(pwr_state == exc_pkg::pwr_stop))
		else $error("masked pin woke stop");

	nmi_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_stop && nmi_active) |=> (pwr_state != exc_pkg::pwr_stop))
		else $error("nonmaskable pin did not wake stop");

	delay_applied_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_stop && stop_wake && restart_delay_bit) |=>
		(pwr_state == exc_pkg::pwr_restart && !clocks_run))
		else $error("restart delay skipped");

	cold_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwr_state == exc_pkg::pwr_boot) |=> (pwr_state == ($past(cold_start) ? exc_pkg::pwr_restart : exc_pkg::pwr_run)))
		else $error("power-on delay handling wrong");

endmodule
`default_nettype wire

// file: rtl/exc_pkg.sv
package exc_pkg;

	// register byte offsets
	localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h04;

	// control register fields
	localparam int          CTRL_DELAY_BIT = 0;
	localparam int          CTRL_WDOG_BIT  = 1;
	localparam int          CTRL_EDGE_BIT  = 2;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;

	// status register fields
	localparam int          STAT_X_BIT      = 0;
	localparam int          STAT_I_BIT      = 1;
	localparam int          STAT_S_BIT      = 2;
	localparam int          STAT_TRAP_BIT   = 3;
	localparam int          STAT_SWI_BIT    = 4;
	localparam int          STAT_EDGE_BIT   = 5;
	localparam int          STAT_STATE_LSB  = 8;
	localparam int          STAT_STATE_W    = 3;
	localparam int          STAT_CAUSE_LSB  = 12;
	localparam int          STAT_CAUSE_W    = 3;

	// stabilisation delay, in sys_clk cycles
	localparam int          RESTART_DELAY_DEFAULT = 4096;

	// opcode map geometry: four pages of 256 opcodes
	localparam int          OPCODE_PAGES  = 4;
	localparam int          OPCODE_ADDR_W = 10;
	localparam int          OPCODE_MAP_W  = 1024;

	typedef enum logic [2:0] {
		pwr_boot,
		pwr_run,
		pwr_wait,
		pwr_stop,
		pwr_restart
	} power_state_t;

	typedef enum logic [2:0] {
		cause_none,
		cause_illegal,
		cause_swi,
		cause_nmi,
		cause_irq_pin,
		cause_source
	} cause_t;

endpackage

// file: rtl/opcode_map_if.sv
`timescale 1ns/1ps
`default_nettype none
interface opcode_map_if;
	logic                                rd_en;
	logic [exc_pkg::OPCODE_ADDR_W-1:0]   addr;
	logic                                implemented;

	modport ctrl (output rd_en, output addr, input implemented);
	modport rom  (input rd_en, input addr, output implemented);
endinterface
`default_nettype wire

// file: rtl/opcode_map_rom.sv
`timescale 1ns/1ps
`default_nettype none
module opcode_map_rom #(
	parameter logic [exc_pkg::OPCODE_MAP_W-1:0] IMPLEMENTED_MAP = '1
)(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// lookup port
	opcode_map_if.rom        map
);

	// registered read keeps the decode off the fetch path
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			map.implemented <= 1'b1;
		else if (map.rd_en)
			map.implemented <= IMPLEMENTED_MAP[map.addr];
	end

endmodule
`default_nettype wire

// file: verification/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// bench commands
	input  wire logic irq_req,
	input  wire logic nonmask_req,
	// open-drain request pins, pulled up while released
	output logic      irq_pin_n,
	output logic      nonmaskable_request_pin_n
);
	// pins move just after an edge, never mid-cycle, so the unit sees clean levels
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_pin_n                 <= 1'b1;
			nonmaskable_request_pin_n <= 1'b1;
		end
		else
		begin
			irq_pin_n                 <= ~irq_req;
			nonmaskable_request_pin_n <= ~nonmask_req;
		end
	end
endmodule
`default_nettype wire

// file: verification/exception_lowpower_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module exception_lowpower_unit_bench;
	// page 1 opcode 05 left unimplemented so the trap can fire
	localparam logic [exc_pkg::OPCODE_MAP_W-1:0] MAP_HOLE = 1024'h1 << 261;
	localparam int E_TAP = 0, E_RTI = 1, E_TRAP = 2, E_WAIT = 3, E_STOP = 4, E_STACK = 5, E_FETCH = 6;
	logic        sys_clk, rst_n, cold_start, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, op_byte;
	logic [31:0] pwdata, prdata, q;
	logic        irq_req, nonmask_req, irq_pin_n, nonmask_pin_n;
	logic [14:0] src_flag, src_en;
	logic [6:0]  ev;
	logic [2:0]  xis, service_cause;
	logic [1:0]  op_page;
	logic [15:0] op_addr, trap_return_pc, wait_read_addr;
	logic [3:0]  service_source;
	logic        mask_x, mask_i, mask_s, service_req, cpu_halted, wait_read_active, timer_run, osc_enable, clocks_run;
	int          num_errors, check_count;

	pin_partner pins_u (.sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req), .nonmask_req(nonmask_req),
		.irq_pin_n(irq_pin_n), .nonmaskable_request_pin_n(nonmask_pin_n));

	exception_lowpower_unit #(.RESTART_DELAY_CYCLES(8), .IMPLEMENTED_MAP(~MAP_HOLE)) dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .cold_start(cold_start), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_pin_n(irq_pin_n), .nonmaskable_request_pin_n(nonmask_pin_n), .source_flag(src_flag),
		.source_enable(src_en), .opcode_fetch(ev[E_FETCH]), .opcode_page(op_page), .opcode_byte(op_byte),
		.opcode_addr(op_addr), .tap_exec(ev[E_TAP]), .tap_x(xis[2]), .tap_i(xis[1]), .tap_s(xis[0]),
		.rti_exec(ev[E_RTI]), .rti_x(xis[2]), .rti_i(xis[1]), .rti_s(xis[0]),
		.software_trap_instruction(ev[E_TRAP]), .wait_instruction(ev[E_WAIT]), .wait_flags_addr(op_addr),
		.stop_exec(ev[E_STOP]), .flags_stacked(ev[E_STACK]), .mask_x(mask_x), .mask_i(mask_i), .mask_s(mask_s),
		.service_req(service_req), .service_cause(service_cause), .service_source(service_source),
		.trap_return_pc(trap_return_pc), .cpu_halted(cpu_halted), .wait_read_active(wait_read_active),
		.wait_read_addr(wait_read_addr), .timer_run(timer_run), .osc_enable(osc_enable), .clocks_run(clocks_run));

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task stop_test;
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task give_up;
		num_errors++;
		$display("CHECK FAILED %0t wait ran out", $time);
		stop_test;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// samples land on the falling edge, away from the unit's updates
	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task fire(input int k, input logic [2:0] v);
		@(posedge sys_clk);
		ev[k] <= 1'b1;
		xis   <= v;
		@(posedge sys_clk);
		ev    <= '0;
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
			give_up;
		// answer taken at the very edge that sees pready, request dropped only after it
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_run;
		for (int i = 0; i < 40 && cpu_halted !== 1'b0; i++)
			@(negedge sys_clk);
		if (cpu_halted !== 1'b0)
			give_up;
	endtask

	initial
	begin
		{rst_n, psel, penable, pwrite, irq_req, nonmask_req} = '0;
		{paddr, pwdata, src_flag, ev, xis} = '0;
		{cold_start, src_en} = '1;
		{op_page, op_byte, op_addr} = {2'h1, 8'h06, 16'h1234};
		num_errors = 0;
		check_count = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		settle(3);
		chk(cpu_halted, 1'b1);
		chk({mask_x, mask_i, mask_s}, 3'h7);
		wait_run;
		apb(1'b0, exc_pkg::CTRL_OFFSET, 32'h0);
		chk(q, exc_pkg::CTRL_RESET);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		fire(E_TAP, 3'h0);
		fire(E_TAP, 3'h6);
		settle(1);
		chk({mask_x, mask_i, mask_s}, 3'h2);
		fire(E_TAP, 3'h0);
		@(posedge sys_clk);
		src_flag[3] <= 1'b1;
		nonmask_req <= 1'b1;
		settle(3);
		chk(service_cause, exc_pkg::cause_nmi);
		fire(E_STACK, 3'h0);
		nonmask_req <= 1'b0;
		settle(1);
		chk({mask_x, mask_i}, 2'h3);
		fire(E_RTI, 3'h0);
		settle(2);
		chk({mask_x, mask_i, service_cause, service_source}, {2'h0, exc_pkg::cause_source, 4'h3});
		fire(E_STACK, 3'h0);
		settle(1);
		chk({mask_x, mask_i}, 2'h1);
		fire(E_RTI, 3'h0);
		settle(2);
		chk(service_req, 1'b1);
		@(posedge sys_clk);
		src_flag <= '0;
		op_byte  <= 8'h05;
		settle(2);
		chk(service_req, 1'b0);
		fire(E_FETCH, 3'h0);
		settle(4);
		chk({service_cause, trap_return_pc}, {exc_pkg::cause_illegal, 16'h1234});
		fire(E_STACK, 3'h0);
		fire(E_TAP, 3'h3);
		fire(E_TRAP, 3'h3);
		settle(3);
		chk(service_cause, exc_pkg::cause_swi);
		fire(E_STACK, 3'h0);
		fire(E_TAP, 3'h1);
		irq_req <= 1'b1;
		settle(3);
		chk(service_cause, exc_pkg::cause_irq_pin);
		@(posedge sys_clk);
		irq_req <= 1'b0;
		apb(1'b1, exc_pkg::CTRL_OFFSET, 32'h3);
		fire(E_WAIT, 3'h0);
		// the core moves on, the stacked flags address must stay latched
		op_addr <= 16'h5678;
		settle(2);
		chk({cpu_halted, wait_read_active, osc_enable, timer_run}, 4'hF);
		chk(wait_read_addr, 16'h1234);
		@(posedge sys_clk);
		src_flag[0] <= 1'b1;
		settle(3);
		chk({cpu_halted, service_source}, 5'h00);
		@(posedge sys_clk);
		src_flag <= '0;
		fire(E_TAP, 3'h3);
		fire(E_WAIT, 3'h3);
		settle(2);
		chk(timer_run, 1'b0);
		@(posedge sys_clk);
		nonmask_req <= 1'b1;
		settle(3);
		chk(cpu_halted, 1'b0);
		fire(E_STACK, 3'h0);
		nonmask_req <= 1'b0;
		fire(E_STOP, 3'h0);
		settle(2);
		chk({osc_enable, cpu_halted}, 2'h2);
		fire(E_TAP, 3'h6);
		fire(E_STOP, 3'h6);
		irq_req <= 1'b1;
		settle(4);
		chk({osc_enable, clocks_run}, 2'h0);
		@(posedge sys_clk);
		irq_req     <= 1'b0;
		nonmask_req <= 1'b1;
		settle(3);
		chk({cpu_halted, osc_enable}, 2'h3);
		wait_run;
		chk(service_req, 1'b0);
		@(posedge sys_clk);
		nonmask_req <= 1'b0;
		apb(1'b1, exc_pkg::CTRL_OFFSET, 32'h2);
		fire(E_TAP, 3'h4);
		fire(E_STOP, 3'h4);
		irq_req <= 1'b1;
		settle(3);
		chk({cpu_halted, service_cause}, {1'b0, exc_pkg::cause_irq_pin});
		// edge mode: a latched edge wakes stop even with the global mask set
		@(posedge sys_clk);
		irq_req <= 1'b0;
		apb(1'b1, exc_pkg::CTRL_OFFSET, 32'h4);
		apb(1'b0, exc_pkg::CTRL_OFFSET, 32'h0);
		chk(q, 32'h0000_0004);
		fire(E_TAP, 3'h6);
		irq_req <= 1'b1;
		@(posedge sys_clk);
		irq_req <= 1'b0;
		fire(E_STOP, 3'h6);
		settle(3);
		chk(cpu_halted, 1'b0);
		apb(1'b0, exc_pkg::STATUS_OFFSET, 32'h0);
		chk(q, 32'h0000_0123);
		// warm reset in mid-run: no stabilisation delay, masks and delay bit set again
		@(posedge sys_clk);
		cold_start <= 1'b0;
		rst_n      <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		settle(1);
		chk({cpu_halted, mask_x, mask_i, mask_s}, 4'h7);
		apb(1'b0, exc_pkg::CTRL_OFFSET, 32'h0);
		chk(q, exc_pkg::CTRL_RESET);
		stop_test;
	end
endmodule
`default_nettype wire
